// ==== rtl/pss_pkg.sv ====
// Types shared by the sampling store block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pss_pkg;
  typedef struct packed {
    logic [31:0] gpr0, gpr1, gpr2, gpr3, gpr4, gpr5, gpr6, gpr7;
    logic [31:0] flags;
    logic [31:0] ip;
  } pss_state_t;

  typedef struct packed {
    logic        valid;
    logic        thread;
    logic [1:0]  priv;
    logic [5:0]  ev_class;
    logic [15:0] sub_ev;
    logic [15:0] indep_mask;
  } pss_event_t;

  typedef enum logic [1:0] {
    PSS_IDLE  = 2'b00,
    PSS_STORE = 2'b01,
    PSS_RELD  = 2'b10
  } pss_state_e_t;
endpackage : pss_pkg
`default_nettype wire

// ==== rtl/pss_regs.svh ====
// Register offsets, field positions and reset values of the sampling store block.
// Assumes inclusion by bare name from rtl/.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// Byte offsets on the register bus
`define PSS_OFF_ESC      8'h00
`define PSS_OFF_ENABLE   8'h04
`define PSS_OFF_MISC     8'h08
`define PSS_OFF_IDENT    8'h0C
`define PSS_OFF_BASE     8'h10
`define PSS_OFF_INDEX    8'h14
`define PSS_OFF_ABSMAX   8'h18
`define PSS_OFF_THRESH   8'h1C
`define PSS_OFF_RELOAD   8'h20
`define PSS_OFF_COUNT    8'h24
`define PSS_OFF_STATUS   8'h28
`define PSS_OFF_REC_BASE 8'h40
// Event select control fields
`define PSS_THREAD1_USER_QUAL_BIT   0
`define PSS_THREAD1_KERNEL_QUAL_BIT    1
`define PSS_THREAD0_USER_QUAL_BIT   2
`define PSS_THREAD0_KERNEL_QUAL_BIT    3
`define PSS_TAG_EN_BIT   4
`define PSS_TAG_LSB      5
`define PSS_TAG_MSB      8
`define PSS_MASK_LSB     9
`define PSS_MASK_MSB     24
`define PSS_CLASS_LSB    25
`define PSS_CLASS_MSB    30
// Other bits
`define PSS_ENABLE_BIT   24
`define PSS_IDENT_BIT    21
`define PSS_MISC_ABS_BIT 12
// Event classes that allow precise sampling
`define PSS_CLASS_EXEC   6'h0C
`define PSS_CLASS_FRONT  6'h08
`define PSS_CLASS_REPLAY 6'h09
// Status bits
`define PSS_ST_IRQ_BIT   0
`define PSS_ST_FULL_BIT  1
`define PSS_ST_OFF_BIT   2
`define PSS_RESET_ZERO   32'h0000_0000
`define PSS_RESP_OKAY    2'h0
`define PSS_RESP_SLVERR  2'h2
`define PSS_REC_WORDS    4'hA
`endif

// ==== rtl/pss_top.sv ====
// Precise event sampling store: qualified counter, record buffer, AXI4-Lite registers.
// Assumes one clock, core state presented as a struct, software drains records over the bus.
// Overview of operation
// - On counter overflow store GPRs, flags and IP into next buffer slot.
// - After storing, reload counter from programmed reset count and resume.
// - Raise interrupt when buffer index reaches nearly-full threshold.
// - Buffer never wraps; storing stops at absolute maximum.
// - Sampling only for execution, front-end and replay event classes.
// - Only this one sampling counter drives precise sampling.
// - Identify register bit 21 reports debug store available.
// - Sampling-absent flag in misc register reads clear.
// - Enable register bit 24 turns sampling on or off.
// - Sampling interrupt shares the one debug store interrupt output.
// - Debug store disabled on and throughout system management mode.
// - Machine check disables debug store; reset clears it.
// - Thread1 user qualifier counts thread 1 at privilege 1 to 3.
// - Thread1 kernel qualifier counts thread 1 at privilege 0.
// - Thread0 qualifiers bit 2 user, bit 3 kernel likewise.
// - Bit 4 enables tagging; bits 5 to 8 hold tag value.
// - Mask bits 9 to 24 select events within class bits 25 to 30.
// - Thread-independent sub-events count without thread qualification.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pss_regs.svh"

module pss_top #(
  parameter int DEPTH = 8,
  parameter int CW    = 32
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire pss_pkg::pss_event_t ev_in,
  input  wire pss_pkg::pss_state_t core_state,
  input  wire logic               smm_active,
  input  wire logic               mcheck,
  input  wire logic               core_init,
  output logic                    ds_irq,
  output logic [3:0]              uop_tag,
  output logic                    uop_tag_en
);
  localparam int IW = $clog2(DEPTH);
  localparam int RECS = DEPTH * 10;

  // ==========================================================
  // Registers
  logic [31:0] esc_q;
  logic        enable_q;
  logic        ds_off_q;
  logic [31:0] base_q;
  logic [IW:0] index_q;
  logic [IW:0] absmax_q;
  logic [IW:0] thresh_q;
  logic [CW-1:0] reload_q;
  logic [CW-1:0] count_q;
  logic        irq_q;
  logic [31:0] rec_q [RECS];
  pss_pkg::pss_state_e_t st_q;

  // Word write decode used by several processes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // AXI4-Lite write channel
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        wr_go;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= `PSS_RESET_ZERO;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !wr_go;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= `PSS_OFF_STATUS) ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_esc, wr_en, wr_base, wr_idx, wr_max, wr_thr, wr_rld, wr_cnt, wr_st;
  assign wr_esc  = wr_go && awaddr_q == `PSS_OFF_ESC;
  assign wr_en   = wr_go && awaddr_q == `PSS_OFF_ENABLE;
  assign wr_base = wr_go && awaddr_q == `PSS_OFF_BASE;
  assign wr_idx  = wr_go && awaddr_q == `PSS_OFF_INDEX;
  assign wr_max  = wr_go && awaddr_q == `PSS_OFF_ABSMAX;
  assign wr_thr  = wr_go && awaddr_q == `PSS_OFF_THRESH;
  assign wr_rld  = wr_go && awaddr_q == `PSS_OFF_RELOAD;
  assign wr_cnt  = wr_go && awaddr_q == `PSS_OFF_COUNT;
  assign wr_st   = wr_go && awaddr_q == `PSS_OFF_STATUS;

  // ==========================================================
  // Configuration registers
  logic [31:0] wmerge_esc;
  assign wmerge_esc = merge(esc_q, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      esc_q    <= `PSS_RESET_ZERO;
      base_q   <= `PSS_RESET_ZERO;
      absmax_q <= '0;
      thresh_q <= '0;
      reload_q <= '0;
    end else begin
      if (wr_esc) esc_q <= wmerge_esc;
      if (wr_base) base_q <= merge(base_q, wdata_q, wstrb_q);
      if (wr_max) absmax_q <= wdata_q[IW:0];
      if (wr_thr) thresh_q <= wdata_q[IW:0];
      if (wr_rld) reload_q <= wdata_q[CW-1:0];
    end
  end

  // Enable bit; sleep-state and ordering handled by software
  always_ff @(posedge aclk) begin
    if (!aresetn || core_init) begin
      enable_q <= 1'b0;
      ds_off_q <= 1'b0;
    end else begin
      if (wr_en) enable_q <= wdata_q[`PSS_ENABLE_BIT];
      // Machine check or system management entry shuts the store; set wins
      if (mcheck || smm_active) ds_off_q <= 1'b1;
      else if (wr_en && wdata_q[`PSS_ENABLE_BIT]) ds_off_q <= 1'b0;
    end
  end

  // ==========================================================
  // Event qualification
  logic [5:0]  ev_cls;
  logic [15:0] ev_msk;
  logic        ts_hit, ti_hit, cls_ok, cnt_evt;
  assign ev_cls = esc_q[`PSS_CLASS_MSB:`PSS_CLASS_LSB];
  assign ev_msk = esc_q[`PSS_MASK_MSB:`PSS_MASK_LSB];
  assign cls_ok = ev_cls == `PSS_CLASS_EXEC || ev_cls == `PSS_CLASS_FRONT
               || ev_cls == `PSS_CLASS_REPLAY;

  always_comb begin
    logic usr;
    usr = ev_in.priv != 2'h0;
    if (ev_in.thread) begin
      ts_hit = usr ? esc_q[`PSS_THREAD1_USER_QUAL_BIT] : esc_q[`PSS_THREAD1_KERNEL_QUAL_BIT];
    end else begin
      ts_hit = usr ? esc_q[`PSS_THREAD0_USER_QUAL_BIT] : esc_q[`PSS_THREAD0_KERNEL_QUAL_BIT];
    end
  end

  assign ti_hit = |(ev_in.sub_ev & ev_msk & ev_in.indep_mask);
  assign cnt_evt = ev_in.valid && ev_in.ev_class == ev_cls
                && ((|(ev_in.sub_ev & ev_msk & ~ev_in.indep_mask) && ts_hit)
                    || ti_hit);

  logic active;
  assign active = enable_q && !ds_off_q && !smm_active && cls_ok;

  // Tag outputs registered for the retirement tagging logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uop_tag    <= 4'h0;
      uop_tag_en <= 1'b0;
    end else begin
      uop_tag    <= esc_q[`PSS_TAG_MSB:`PSS_TAG_LSB];
      uop_tag_en <= esc_q[`PSS_TAG_EN_BIT];
    end
  end

  // ==========================================================
  // Sampling counter and record store
  logic full;
  assign full = (index_q >= absmax_q) || (index_q >= (IW+1)'(DEPTH));

  always_ff @(posedge aclk) begin
    if (!aresetn || core_init) begin
      count_q <= '0;
      st_q    <= pss_pkg::PSS_IDLE;
    end else begin
      unique case (st_q)
        pss_pkg::PSS_IDLE: begin
          if (wr_cnt) begin
            count_q <= wdata_q[CW-1:0];
          end else if (active && cnt_evt) begin
            if (&count_q) st_q <= pss_pkg::PSS_STORE;
            count_q <= count_q + 1'b1;
          end
        end
        pss_pkg::PSS_STORE: st_q <= pss_pkg::PSS_RELD;
        pss_pkg::PSS_RELD: begin
          count_q <= reload_q;
          st_q    <= pss_pkg::PSS_IDLE;
        end
      endcase
    end
  end

  // Records live in flip-flops; base is kept for software bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= '0;
    end else if (st_q == pss_pkg::PSS_STORE && !full) begin
      index_q <= index_q + 1'b1;
    end else if (wr_idx) begin
      index_q <= wdata_q[IW:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_rec
      always_ff @(posedge aclk) begin
        if (st_q == pss_pkg::PSS_STORE && !full && index_q == (IW+1)'(g)) begin
          rec_q[g*10+0] <= core_state.gpr0;
          rec_q[g*10+1] <= core_state.gpr1;
          rec_q[g*10+2] <= core_state.gpr2;
          rec_q[g*10+3] <= core_state.gpr3;
          rec_q[g*10+4] <= core_state.gpr4;
          rec_q[g*10+5] <= core_state.gpr5;
          rec_q[g*10+6] <= core_state.gpr6;
          rec_q[g*10+7] <= core_state.gpr7;
          rec_q[g*10+8] <= core_state.flags;
          rec_q[g*10+9] <= core_state.ip;
        end
      end
    end
  endgenerate

  // Interrupt: sticky, set wins over the software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q  <= 1'b0;
      ds_irq <= 1'b0;
    end else begin
      if (enable_q && index_q >= thresh_q && thresh_q != '0) irq_q <= 1'b1;
      else if (wr_st && wdata_q[`PSS_ST_IRQ_BIT]) irq_q <= 1'b0;
      ds_irq <= irq_q;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel; records read from offset 0x40 by word
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    int ri;
    ri = 0;
    rd_ok  = 1'b1;
    rd_val = `PSS_RESET_ZERO;
    unique case (s_axi_araddr)
      `PSS_OFF_ESC:    rd_val = esc_q;
      `PSS_OFF_ENABLE: rd_val[`PSS_ENABLE_BIT] = enable_q;
      `PSS_OFF_MISC:   rd_val[`PSS_MISC_ABS_BIT] = 1'b0;
      `PSS_OFF_IDENT:  rd_val[`PSS_IDENT_BIT] = 1'b1;
      `PSS_OFF_BASE:   rd_val = base_q;
      `PSS_OFF_INDEX:  rd_val[IW:0] = index_q;
      `PSS_OFF_ABSMAX: rd_val[IW:0] = absmax_q;
      `PSS_OFF_THRESH: rd_val[IW:0] = thresh_q;
      `PSS_OFF_RELOAD: rd_val[CW-1:0] = reload_q;
      `PSS_OFF_COUNT:  rd_val[CW-1:0] = count_q;
      `PSS_OFF_STATUS: rd_val = {29'h0, ds_off_q, full, irq_q};
      default: begin
        ri = (int'(s_axi_araddr) - int'(`PSS_OFF_REC_BASE)) / 4;
        if (s_axi_araddr >= `PSS_OFF_REC_BASE && ri < RECS) rd_val = rec_q[ri];
        else rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PSS_RESET_ZERO;
      s_axi_rresp   <= `PSS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_wrap; st_q == pss_pkg::PSS_STORE; endsequence
  sequence s_reload; st_q == pss_pkg::PSS_RELD ##1 count_q == $past(reload_q); endsequence

  store_reload_a: assert property (@(posedge aclk) disable iff (!aresetn || core_init)
    s_wrap |=> s_reload) else $error("reload missing after store");
  no_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full && !wr_idx |=> index_q == $past(index_q)) else $error("index moved when full");
  irq_thresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_q && thresh_q != '0 && index_q >= thresh_q |-> ##2 ds_irq)
    else $error("no interrupt at threshold");
  smm_off_a: assert property (@(posedge aclk) disable iff (!aresetn || core_init)
    smm_active |=> ds_off_q) else $error("store on in smm");
  mcheck_off_a: assert property (@(posedge aclk) disable iff (!aresetn || core_init)
    mcheck |=> ds_off_q) else $error("store on after machine check");
  no_qual_a: assert property (@(posedge aclk) disable iff (!aresetn)
    esc_q[3:0] == 4'h0 && ev_in.indep_mask == 16'h0 |-> !cnt_evt)
    else $error("count with no qualifier");
  class_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cls_ok && st_q == pss_pkg::PSS_IDLE |=> st_q == pss_pkg::PSS_IDLE)
    else $error("sampling bad class");
  enable_off_a: assert property (@(posedge aclk) disable iff (!aresetn || core_init)
    !enable_q && st_q == pss_pkg::PSS_IDLE && !wr_cnt |=> $stable(count_q))
    else $error("counting while disabled");
endmodule : pss_top
`default_nettype wire

// ==== tb/pss_core_model.sv ====
// Core model: the retired-event stream and architectural state seen by the store block.
// Assumes fire is called by the bench just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module pss_core_model (
  input  wire logic               aclk,
  output var  pss_pkg::pss_event_t ev_in,
  output var  pss_pkg::pss_state_t core_state
);
  // ==========================================================
  // Event source
  initial begin
    ev_in      = '0;
    core_state = '0;
  end

  // One event for one cycle; state holds, as real registers do between events
  task automatic fire(input pss_pkg::pss_event_t ev, input pss_pkg::pss_state_t st);
    @(posedge aclk);
    ev_in      <= ev;
    core_state <= st;
    @(posedge aclk);
    ev_in.valid <= 1'b0;
  endtask : fire
endmodule : pss_core_model
`default_nettype wire

// ==== tb/test_precise_event_sampling_store.sv ====
// Bench of the sampling store: bus master, event source, queue of expected reads.
// Assumes the register map header, the core model and one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "pss_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module test_precise_event_sampling_store;
  localparam logic [1:0] RS_OK = `PSS_RESP_OKAY;
  localparam logic [1:0] RS_ER = `PSS_RESP_SLVERR;
  localparam logic [31:0] ESC_S = {1'b0, `PSS_CLASS_EXEC, 16'h0001, 5'h00, 4'hF};
  logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid;
  logic                smm_active, mcheck, core_init, ds_irq, uop_tag_en;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata, rnd, reload;
  logic [1:0]          bresp, rresp;
  logic [3:0]          uop_tag;
  logic [65:0]         note;
  logic [65:0]         exp_q[$];
  pss_pkg::pss_event_t ev_in;
  pss_pkg::pss_state_t core_state, st_a, st_b, st_f0, st;
  int                  err_count, checked, t;

  pss_top #(.DEPTH(8), .CW(32)) i_pss_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_in(ev_in), .core_state(core_state), .smm_active(smm_active), .mcheck(mcheck),
    .core_init(core_init), .ds_irq(ds_irq), .uop_tag(uop_tag), .uop_tag_en(uop_tag_en));
  pss_core_model i_pss_core_model (.aclk(aclk), .ev_in(ev_in), .core_state(core_state));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic pss_pkg::pss_state_t rnd_state();
    pss_pkg::pss_state_t s;
    for (int w = 0; w < 10; w++) begin
      rnd = lfsr(rnd);
      s[32*w +: 32] = rnd;
    end
    return s;
  endfunction : rnd_state

  // Record word order: gpr0..gpr7, flags, ip
  function automatic logic [31:0] word(input pss_pkg::pss_state_t s, input int w);
    return s[(9-w)*32 +: 32];
  endfunction : word

  task automatic tally_and_finish;
    $display("counts: %0d compared, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hang(input int n);
    if (n >= 100) begin
      err_count++;
      $display("mismatch at %0t: bus answer never came", $time);
      tally_and_finish();
    end
  endtask : hang

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (t = 0; t < 100 && bvalid !== 1'b1; t++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    hang(t);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    exp_q.push_back({er, m, e});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (t = 0; t < 100 && rvalid !== 1'b1; t++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    hang(t);
    rready <= 1'b0;
  endtask : rd

  // Read results are judged against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : ~66'h0;
      `CHK(rdata & note[63:32], note[31:0])
      `CHK(rresp, note[65:64])
    end
  end

  task automatic ev(input logic thr, input logic [1:0] pr, input logic [5:0] cls,
                    input logic [15:0] sub, input logic [15:0] ind, input pss_pkg::pss_state_t s);
    i_pss_core_model.fire('{valid: 1'b1, thread: thr, priv: pr, ev_class: cls,
                            sub_ev: sub, indep_mask: ind}, s);
    repeat (8) @(posedge aclk);
  endtask : ev

  task automatic qcase(input logic [3:0] q, input logic thr, input logic [1:0] pr,
                       input logic [15:0] sub, input logic [15:0] ind,
                       input logic [5:0] cls, input logic e);
    wr(`PSS_OFF_ESC, {1'b0, `PSS_CLASS_EXEC, 16'h0001, 5'h00, q}, RS_OK);
    wr(`PSS_OFF_COUNT, 32'h0, RS_OK);
    ev(thr, pr, cls, sub, ind, st_a);
    rd(`PSS_OFF_COUNT, {31'h0, e}, 32'hFFFF_FFFF, RS_OK);
  endtask : qcase

  task automatic ovf(input pss_pkg::pss_state_t s);
    wr(`PSS_OFF_COUNT, 32'hFFFF_FFFF, RS_OK);
    ev(1'b0, 2'h0, `PSS_CLASS_EXEC, 16'h0001, 16'h0, s);
  endtask : ovf

  // A store that must not happen would overwrite slot 0
  task automatic blk;
    wr(`PSS_OFF_INDEX, 32'h0, RS_OK);
    ovf(st_b);
    rd(`PSS_OFF_REC_BASE, word(st_a, 0), 32'hFFFF_FFFF, RS_OK);
  endtask : blk

  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {smm_active, mcheck, core_init, awaddr, araddr, wdata} = '0;
    {err_count, checked} = '0;
    rnd = 32'h109E_DB46;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`PSS_OFF_IDENT, 32'h0020_0000, 32'h0020_0000, RS_OK);
    rd(`PSS_OFF_MISC, 32'h0, 32'h0000_1000, RS_OK);
    rd(8'h30, 32'h0, 32'hFFFF_FFFF, RS_ER);
    wr(8'h30, 32'hFFFF_FFFF, RS_ER);
    $display("test identify done");
    rnd = lfsr(rnd);
    reload = rnd & 32'h00FF_FFFF;
    wr(`PSS_OFF_INDEX, 32'h0, RS_OK);
    wr(`PSS_OFF_ABSMAX, 32'd8, RS_OK);
    wr(`PSS_OFF_THRESH, 32'd2, RS_OK);
    wr(`PSS_OFF_RELOAD, reload, RS_OK);
    wr(`PSS_OFF_ENABLE, 32'h0100_0000, RS_OK);
    wr(`PSS_OFF_ESC, ESC_S, RS_OK);
    rd(`PSS_OFF_ESC, ESC_S, 32'h7FFF_FFFF, RS_OK);
    st_a = rnd_state();
    qcase(4'h1, 1'b1, 2'h3, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'h1, 1'b1, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'h1, 1'b0, 2'h3, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'h2, 1'b1, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'h2, 1'b1, 2'h1, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'h3, 1'b1, 2'h2, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'h4, 1'b0, 2'h2, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'h4, 1'b0, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'h8, 1'b0, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'hC, 1'b0, 2'h1, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b1);
    qcase(4'h8, 1'b1, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'h0, 1'b0, 2'h0, 16'h1, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'hF, 1'b0, 2'h0, 16'h2, 16'h0, `PSS_CLASS_EXEC, 1'b0);
    qcase(4'hF, 1'b0, 2'h0, 16'h1, 16'h0, `PSS_CLASS_FRONT, 1'b0);
    qcase(4'h0, 1'b1, 2'h0, 16'h1, 16'h1, `PSS_CLASS_EXEC, 1'b1);
    $display("test qualifiers done");
    wr(`PSS_OFF_ESC, ESC_S, RS_OK);
    wr(`PSS_OFF_INDEX, 32'h0, RS_OK);
    ovf(st_a);
    for (int w = 0; w < 10; w++) begin
      rd(`PSS_OFF_REC_BASE + 8'(4 * w), word(st_a, w), 32'hFFFF_FFFF, RS_OK);
    end
    rd(`PSS_OFF_COUNT, reload, 32'hFFFF_FFFF, RS_OK);
    $display("test store done");
    st_b = rnd_state();
    wr(`PSS_OFF_ENABLE, 32'h0, RS_OK);
    blk();
    wr(`PSS_OFF_ENABLE, 32'h0100_0000, RS_OK);
    smm_active <= 1'b1;
    blk();
    smm_active <= 1'b0;
    wr(`PSS_OFF_ENABLE, 32'h0100_0000, RS_OK);
    mcheck <= 1'b1;
    @(posedge aclk);
    mcheck <= 1'b0;
    blk();
    core_init <= 1'b1;
    @(posedge aclk);
    core_init <= 1'b0;
    rd(`PSS_OFF_ENABLE, 32'h0, 32'h0100_0000, RS_OK);
    wr(`PSS_OFF_ENABLE, 32'h0100_0000, RS_OK);
    wr(`PSS_OFF_ESC, {1'b0, 6'h01, 16'h0001, 5'h00, 4'hF}, RS_OK);
    // Event of the programmed class, so only the class gate can stop it
    wr(`PSS_OFF_INDEX, 32'h0, RS_OK);
    wr(`PSS_OFF_COUNT, 32'hFFFF_FFFF, RS_OK);
    ev(1'b0, 2'h0, 6'h01, 16'h0001, 16'h0, st_b);
    rd(`PSS_OFF_REC_BASE, word(st_a, 0), 32'hFFFF_FFFF, RS_OK);
    rd(`PSS_OFF_COUNT, 32'hFFFF_FFFF, 32'hFFFF_FFFF, RS_OK);
    wr(`PSS_OFF_ESC, ESC_S, RS_OK);
    $display("test gating done");
    wr(`PSS_OFF_INDEX, 32'h0, RS_OK);
    wr(`PSS_OFF_STATUS, 32'h1, RS_OK);
    for (int i = 0; i <= 8; i++) begin
      st = rnd_state();
      if (i == 0) st_f0 = st;
      ovf(st);
      if (i == 0) `CHK(ds_irq, 1'b0)
      if (i == 1) `CHK(ds_irq, 1'b1)
    end
    rd(`PSS_OFF_STATUS, 32'h2, 32'h2, RS_OK);
    rd(`PSS_OFF_REC_BASE, word(st_f0, 0), 32'hFFFF_FFFF, RS_OK);
    $display("test fill done");
    wr(`PSS_OFF_ESC, ESC_S | 32'h0000_0150, RS_OK);
    repeat (3) @(posedge aclk);
    `CHK(uop_tag, 4'hA)
    `CHK(uop_tag_en, 1'b1)
    wr(`PSS_OFF_ESC, ESC_S, RS_OK);
    repeat (3) @(posedge aclk);
    `CHK(uop_tag_en, 1'b0)
    $display("test tagging done");
    tally_and_finish();
  end
endmodule : test_precise_event_sampling_store
`default_nettype wire
